/* File: design/aszc_consts.svh */
`ifndef ASZC_CONSTS_SVH
`define ASZC_CONSTS_SVH

// register byte offsets
`define ASZC_OFS_CTRL       12'h000
`define ASZC_OFS_CLKDIV     12'h004
`define ASZC_OFS_FLAGS      12'h00C
`define ASZC_OFS_TXDATA     12'h010
`define ASZC_OFS_RXDATA     12'h014

// control fields
`define ASZC_CTRL_RUN       0
`define ASZC_CTRL_TXLIM_LSB 9
`define ASZC_CTRL_RXLIM_LSB 12
`define ASZC_CTRL_MCLK_ON   15
`define ASZC_CTRL_RZCEN     16
`define ASZC_CTRL_LZCEN     17
`define ASZC_CTRL_WMASK     32'h0003_FE01
`define ASZC_CTRL_RESET     32'h0000_0000

// flags fields
`define ASZC_FLG_LZC        0
`define ASZC_FLG_RZC        1
`define ASZC_FLG_RXLIM      2
`define ASZC_FLG_TXLIM      3
`define ASZC_FLG_RXLVL_LSB  4
`define ASZC_FLG_TXLVL_LSB  8

// clock divider field
`define ASZC_CLKDIV_RESET   3'h0

// fifo and frame geometry
`define ASZC_FIFO_DEPTH     8
`define ASZC_FRAME_LAST     5'h1F
`define ASZC_BCLK_HALF      8'h04

`endif

/* File: design/aszc_pkg.sv */
package aszc_pkg;

   typedef enum logic [1:0] {
      aszc_idle,
      aszc_shift,
      aszc_push
   } aszc_eng_type;

   typedef struct packed {
      logic mclk;
      logic bclk;
      logic lrclk;
      logic sdo;
   } aszc_serial_type;

   typedef struct packed {
      logic [31:0]      ctrl;
      logic [2:0]       mclk_div;
      logic             lzc;
      logic             rzc;
      logic             rx_th_flag;
      logic             tx_th_flag;
      logic [7:0][31:0] txmem;
      logic [2:0]       tx_rd;
      logic [2:0]       tx_wr;
      logic [3:0]       tx_cnt;
      logic [7:0][31:0] rxmem;
      logic [2:0]       rx_rd;
      logic [2:0]       rx_wr;
      logic [3:0]       rx_cnt;
      aszc_eng_type     eng;
      logic [4:0]       bit_cnt;
      logic [7:0]       tick_cnt;
      logic [31:0]      shift_tx;
      logic [31:0]      shift_rx;
      logic             prev_lsign;
      logic             prev_rsign;
      logic [2:0]       mclk_cnt;
      logic             sdi_s1;
      logic             sdi_s2;
      aszc_serial_type  pins;
      logic [31:0]      prdata;
   } aszc_ctl_state_type;

endpackage

/* File: design/aszc_buf.sv */
module aszc_buf #(
   parameter int W = 32
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   typedef struct packed {
      logic [1:0][W-1:0] slot;
      logic [1:0]        cnt;
   } aszc_buf_state_type;

   aszc_buf_state_type q;
   aszc_buf_state_type d;
   logic               push;
   logic               pop;

   assign in_ready  = (q.cnt != 2'h2);
   assign out_valid = (q.cnt != 2'h0);
   assign out_data  = q.slot[0];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      d = q;
      if (pop) begin
         d.slot[0] = q.slot[1];
      end
      // slot index after a same-cycle pop moves down by one
      if (push) begin
         if (q.cnt == 2'h0 || (pop && q.cnt == 2'h1)) begin
            d.slot[0] = in_data;
         end else begin
            d.slot[1] = in_data;
         end
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule // aszc_buf

/* File: design/aszc_ctl.sv */
// Operation
// - left enable: sign change or zero sets flag
// - right enable: sign change or zero sets flag
// - disabled channel: no detection, no flag set
// - master clock enable gates codec clock
// - divide clock by 2N for 256fs
// - receive flag when level at or above threshold
// - receive threshold code means value plus one
// - transmit flag when level at or below threshold
// - transmit threshold code means value itself
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`include "aszc_consts.svh"

module aszc_ctl #(
   parameter logic [7:0] BCLK_HALF = `ASZC_BCLK_HALF
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             sdi,
   output aszc_pkg::aszc_serial_type pins,
   output logic                  left_zero_cross_flag,
   output logic                  right_zero_cross_flag,
   output logic                  receive_fill_threshold_flag,
   output logic                  transmit_drain_threshold_flag
);

   localparam logic [3:0] DEPTH = 4'(`ASZC_FIFO_DEPTH);

   aszc_pkg::aszc_ctl_state_type q;
   aszc_pkg::aszc_ctl_state_type d;

   logic        setup;
   logic        access;
   logic        addr_ok;
   logic        tx_push;
   logic        tx_pop;
   logic        rx_push;
   logic        rx_pop;
   logic        load;
   logic        tick;
   logic [31:0] next_word;
   logic        buf_in_valid;
   logic        buf_in_ready;
   logic        buf_out_valid;
   logic        buf_out_ready;
   logic [31:0] buf_out_data;
   logic [2:0]  rx_th;
   logic [2:0]  tx_th;
   logic [2:0]  mclk_top;
   logic [31:0] flags_word;

   function automatic logic [3:0] lvl_next(
      input logic [3:0] cnt,
      input logic       push,
      input logic       pop
   );
      lvl_next = cnt + {3'h0, push} - {3'h0, pop};
   endfunction

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `ASZC_OFS_CTRL) || (a == `ASZC_OFS_CLKDIV) ||
                   (a == `ASZC_OFS_FLAGS) || (a == `ASZC_OFS_TXDATA) ||
                   (a == `ASZC_OFS_RXDATA);
   endfunction

   // sign change against the previous sample, or an all-zero channel
   function automatic logic crossing(
      input logic [15:0] half,
      input logic        prev_sign
   );
      crossing = (half[15] != prev_sign) || (half == 16'h0000);
   endfunction

   // rx words stall the frame engine here once the fifo is full and both buffer slots hold words
   aszc_buf #(
      .W (32)
   ) u_rx_buf (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (buf_in_valid),
      .in_data   (q.shift_rx),
      .in_ready  (buf_in_ready),
      .out_valid (buf_out_valid),
      .out_data  (buf_out_data),
      .out_ready (buf_out_ready)
   );

   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign addr_ok = known_addr(paddr);

   // zero wait state; read data is prepared during setup
   assign pready  = 1'b1;
   assign pslverr = access & (~addr_ok |
                    (pwrite & (paddr == `ASZC_OFS_TXDATA) & (q.tx_cnt == DEPTH)) |
                    (pwrite & (paddr == `ASZC_OFS_RXDATA)));
   assign prdata  = q.prdata;

   assign tx_push = access & pwrite & (paddr == `ASZC_OFS_TXDATA) &
                    (q.tx_cnt != DEPTH);
   assign rx_pop  = access & ~pwrite & (paddr == `ASZC_OFS_RXDATA) &
                    (q.rx_cnt != 4'h0);

   assign buf_out_ready = (q.rx_cnt != DEPTH);
   assign rx_push       = buf_out_valid & buf_out_ready;
   assign buf_in_valid  = (q.eng == aszc_pkg::aszc_push);

   assign rx_th    = q.ctrl[`ASZC_CTRL_RXLIM_LSB +: 3];
   assign tx_th    = q.ctrl[`ASZC_CTRL_TXLIM_LSB +: 3];
   assign mclk_top = (q.mclk_div == 3'h0) ? 3'h0 : q.mclk_div - 3'h1;
   assign tick     = (q.tick_cnt == BCLK_HALF - 8'h01);

   // frame load: from idle on run, or after the rx word is handed off
   assign load = q.ctrl[`ASZC_CTRL_RUN] &
                 ((q.eng == aszc_pkg::aszc_idle) ||
                  (q.eng == aszc_pkg::aszc_push && buf_in_ready));
   assign tx_pop    = load & (q.tx_cnt != 4'h0);
   // underrun sends silence rather than stale data
   assign next_word = (q.tx_cnt != 4'h0) ? q.txmem[q.tx_rd] : 32'h0000_0000;

   always_comb begin
      flags_word = 32'h0000_0000;
      flags_word[`ASZC_FLG_LZC]           = q.lzc;
      flags_word[`ASZC_FLG_RZC]           = q.rzc;
      flags_word[`ASZC_FLG_RXLIM]         = q.rx_th_flag;
      flags_word[`ASZC_FLG_TXLIM]         = q.tx_th_flag;
      flags_word[`ASZC_FLG_RXLVL_LSB +: 4] = q.rx_cnt;
      flags_word[`ASZC_FLG_TXLVL_LSB +: 4] = q.tx_cnt;
   end

   always_comb begin
      d = q;

      // double flop on the serial input pin
      d.sdi_s1 = sdi;
      d.sdi_s2 = q.sdi_s1;

      // register writes
      if (access && pwrite) begin
         unique case (paddr)
            `ASZC_OFS_CTRL: begin
               d.ctrl = pwdata & `ASZC_CTRL_WMASK;
            end
            `ASZC_OFS_CLKDIV: begin
               d.mclk_div = pwdata[2:0];
            end
            `ASZC_OFS_FLAGS: begin
               if (pwdata[`ASZC_FLG_LZC]) begin
                  d.lzc = 1'b0;
               end
               if (pwdata[`ASZC_FLG_RZC]) begin
                  d.rzc = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // read data captured in setup so prdata comes from a flop
      if (setup) begin
         unique case (paddr)
            `ASZC_OFS_CTRL:   d.prdata = q.ctrl;
            `ASZC_OFS_CLKDIV: d.prdata = {29'h0000_0000, q.mclk_div};
            `ASZC_OFS_FLAGS:  d.prdata = flags_word;
            `ASZC_OFS_RXDATA: d.prdata = (q.rx_cnt != 4'h0) ?
                                         q.rxmem[q.rx_rd] : 32'h0000_0000;
            default:          d.prdata = 32'h0000_0000;
         endcase
      end

      // transmit fifo
      if (tx_push) begin
         d.txmem[q.tx_wr] = pwdata;
         d.tx_wr          = q.tx_wr + 3'h1;
      end
      if (tx_pop) begin
         d.tx_rd = q.tx_rd + 3'h1;
      end
      d.tx_cnt = lvl_next(q.tx_cnt, tx_push, tx_pop);

      // receive fifo
      if (rx_push) begin
         d.rxmem[q.rx_wr] = buf_out_data;
         d.rx_wr          = q.rx_wr + 3'h1;
      end
      if (rx_pop) begin
         d.rx_rd = q.rx_rd + 3'h1;
      end
      d.rx_cnt = lvl_next(q.rx_cnt, rx_push, rx_pop);

      // compared every cycle, never latched
      d.rx_th_flag = (q.rx_cnt >= {1'b0, rx_th} + 4'h1);
      d.tx_th_flag = (q.tx_cnt <= {1'b0, tx_th});

      // frame engine: 16 left bits then 16 right bits, msb first
      unique case (q.eng)
         aszc_pkg::aszc_idle: begin
            d.tick_cnt  = 8'h00;
            d.bit_cnt   = 5'h00;
            d.pins.bclk = 1'b0;
         end
         aszc_pkg::aszc_shift: begin
            if (!q.ctrl[`ASZC_CTRL_RUN]) begin
               d.eng       = aszc_pkg::aszc_idle;
               d.pins.bclk = 1'b0;
            end else if (tick) begin
               d.tick_cnt  = 8'h00;
               d.pins.bclk = ~q.pins.bclk;
               if (!q.pins.bclk) begin
                  // rising bit clock: sample the codec data
                  d.shift_rx = {q.shift_rx[30:0], q.sdi_s2};
               end else if (q.bit_cnt == `ASZC_FRAME_LAST) begin
                  d.eng = aszc_pkg::aszc_push;
               end else begin
                  d.shift_tx = {q.shift_tx[30:0], 1'b0};
                  d.bit_cnt  = q.bit_cnt + 5'h01;
               end
            end else begin
               d.tick_cnt = q.tick_cnt + 8'h01;
            end
         end
         aszc_pkg::aszc_push: begin
            // bit clock holds low while the buffer is full
            if (!q.ctrl[`ASZC_CTRL_RUN] && buf_in_ready) begin
               d.eng = aszc_pkg::aszc_idle;
            end
         end
      endcase

      if (load) begin
         d.eng      = aszc_pkg::aszc_shift;
         d.shift_tx = next_word;
         d.bit_cnt  = 5'h00;
         d.tick_cnt = 8'h00;
         d.prev_lsign = next_word[31];
         d.prev_rsign = next_word[15];
         if (q.ctrl[`ASZC_CTRL_LZCEN] &&
             crossing(next_word[31:16], q.prev_lsign)) begin
            d.lzc = 1'b1;
         end
         if (q.ctrl[`ASZC_CTRL_RZCEN] &&
             crossing(next_word[15:0], q.prev_rsign)) begin
            d.rzc = 1'b1;
         end
      end

      d.pins.lrclk = d.bit_cnt[4];
      d.pins.sdo   = d.shift_tx[31];

      // codec master clock, half period of N cycles, one cycle when N is zero
      if (!q.ctrl[`ASZC_CTRL_MCLK_ON]) begin
         d.mclk_cnt  = 3'h0;
         d.pins.mclk = 1'b0;
      end else if (q.mclk_cnt >= mclk_top) begin
         d.mclk_cnt  = 3'h0;
         d.pins.mclk = ~q.pins.mclk;
      end else begin
         d.mclk_cnt = q.mclk_cnt + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q          <= '0;
         q.ctrl     <= `ASZC_CTRL_RESET;
         q.mclk_div <= `ASZC_CLKDIV_RESET;
         q.eng      <= aszc_pkg::aszc_idle;
      end else begin
         q <= d;
      end
   end

   assign pins                          = q.pins;
   assign left_zero_cross_flag          = q.lzc;
   assign right_zero_cross_flag         = q.rzc;
   assign receive_fill_threshold_flag   = q.rx_th_flag;
   assign transmit_drain_threshold_flag = q.tx_th_flag;

endmodule // aszc_ctl

/* File: verification/aszc_ctl_sva.sv */
module aszc_ctl_sva (
   input wire logic                      clock,
   input wire logic                      rst_n,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [11:0]               paddr,
   input wire logic [31:0]               pwdata,
   input wire aszc_pkg::aszc_serial_type pins,
   input wire logic                      left_zero_cross_flag,
   input wire logic                      right_zero_cross_flag,
   input wire logic                      receive_fill_threshold_flag,
   input wire logic                      transmit_drain_threshold_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ctrl_q;
   logic [3:0]  txn_q, cnt_q;
   logic [2:0]  div_q;
   logic        ran_q, seen_q, mprev_q;
   wire         wr = psel && penable && pwrite;
   wire         tog = pins.mclk != mprev_q;
   wire         lclr = wr && paddr == 12'h00C && pwdata[0];
   wire [3:0]   neff = (div_q == 3'h0) ? 4'h1 : {1'b0, div_q};

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // fifo level is only known before the first run
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= 32'h0000_0000;
         div_q   <= 3'h0;
         txn_q   <= 4'h0;
         cnt_q   <= 4'h0;
         ran_q   <= 1'b0;
         seen_q  <= 1'b0;
         mprev_q <= 1'b0;
      end else begin
         mprev_q <= pins.mclk;
         cnt_q   <= tog ? 4'h1 : cnt_q + {3'h0, cnt_q != 4'hF};
         seen_q  <= (wr && paddr[11:3] == 9'h000) ? 1'b0 : (seen_q || tog);
         if (wr && paddr == 12'h000) ctrl_q <= pwdata & 32'h0003_FE01;
         if (wr && paddr == 12'h004) div_q <= pwdata[2:0];
         if (wr && paddr == 12'h010 && txn_q < 4'h8) txn_q <= txn_q + 4'h1;
         if (wr && paddr == 12'h000 && pwdata[0]) ran_q <= 1'b1;
      end
   end

   sequence s_mclk_on;
      $rose(ctrl_q[15]);
   endsequence
   sequence s_mclk_high;
      ##[1:20] pins.mclk;
   endsequence

   property p_mclk_off;
      !ctrl_q[15] && !$past(ctrl_q[15]) |-> !pins.mclk;
   endproperty
   property p_mclk_start;
      s_mclk_on |-> s_mclk_high;
   endproperty
   property p_mclk_period;
      // the forced fall when the clock is switched off is not a period
      tog && seen_q && ctrl_q[15] |-> cnt_q == neff;
   endproperty
   property p_lzc_gate;
      $rose(left_zero_cross_flag) |-> $past(ctrl_q[17]);
   endproperty
   property p_rzc_gate;
      $rose(right_zero_cross_flag) |-> $past(ctrl_q[16]);
   endproperty
   property p_lzc_hold;
      left_zero_cross_flag && !lclr |=> left_zero_cross_flag;
   endproperty
   property p_txth;
      !ran_q && $past(rst_n) |->
         transmit_drain_threshold_flag == ($past(txn_q) <= {1'b0, $past(ctrl_q[11:9])});
   endproperty
   property p_rxth;
      !ran_q && $past(rst_n) |-> !receive_fill_threshold_flag;
   endproperty

   a_mclk_off: assert property (p_mclk_off) else $error("mclk runs while off");
   a_mclk_start: assert property (p_mclk_start) else $error("mclk never starts");
   a_mclk_period: assert property (p_mclk_period) else $error("mclk period wrong");
   a_lzc_gate: assert property (p_lzc_gate) else $error("left flag while off");
   a_rzc_gate: assert property (p_rzc_gate) else $error("right flag while off");
   a_lzc_hold: assert property (p_lzc_hold) else $error("left flag lost");
   a_txth: assert property (p_txth) else $error("tx flag wrong");
   a_rxth: assert property (p_rxth) else $error("rx flag while empty");
endmodule // aszc_ctl_sva

bind aszc_ctl aszc_ctl_sva u_aszc_ctl_sva (.clock, .rst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pins, .left_zero_cross_flag, .right_zero_cross_flag,
   .receive_fill_threshold_flag, .transmit_drain_threshold_flag);

/* File: verification/aszc_codec.sv */
module aszc_codec (
   input wire aszc_pkg::aszc_serial_type pins,
   output logic                          sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] pat = 32'h5A5A_0F0F;
   initial sdi = 1'b0;
   // moves on the falling bit clock so the port samples a settled level
   always @(negedge pins.bclk) begin
      sdi <= pat[31];
      pat <= {pat[30:0], ~pat[31]};
   end
endmodule // aszc_codec

/* File: verification/aszc_ctl_test.sv */
module aszc_ctl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      clock = 1'b0;
   logic                      rst_n = 1'b0;
   logic                      psel = 1'b0;
   logic                      penable = 1'b0;
   logic                      pwrite = 1'b0;
   logic [11:0]               paddr = 12'h000;
   logic [31:0]               pwdata = 32'h0000_0000;
   logic [31:0]               prdata, rd, w, c;
   logic                      pready, pslverr, err, sdi, lzc, rzc, rxf, txf, fl, fr, sl, sr;
   aszc_pkg::aszc_serial_type pins;
   logic [31:0]               txq[$];
   int                        fail_count = 0;
   int                        samples_checked = 0;
   int                        cyc = 0;
   int                        k;

   always #12.5 clock = ~clock;

   // short bit clock keeps the fill run brief
   aszc_ctl #(.BCLK_HALF(8'h02)) u_aszc_ctl (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sdi(sdi), .pins(pins), .left_zero_cross_flag(lzc), .right_zero_cross_flag(rzc),
      .receive_fill_threshold_flag(rxf), .transmit_drain_threshold_flag(txf));
   aszc_codec u_aszc_codec (.pins(pins), .sdi(sdi));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] dat);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr_en;
      paddr   <= a;
      pwdata  <= dat;
      @(posedge clock);
      penable <= 1'b1;
      // only the bench timeout ends a wait for the slave
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      w = $urandom(95);
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      // fill the tx fifo one word at a time, sweeping every code
      for (k = 0; k <= 8; k++) begin
         for (c = 0; c < 8; c++) begin
            apb(1'b1, 12'h000, (c << 12) | (c << 9));
            repeat (2) @(posedge clock);
            chk(32'(txf), 32'(k <= c));
            chk(32'(rxf), 32'h0000_0000);
         end
         w = $urandom;
         if ($urandom % 3 == 0) w[31:16] = 16'h0000;
         if ($urandom % 3 == 0) w[15:0] = 16'h0000;
         apb(1'b1, 12'h010, w);
         chk(32'(err), 32'(k == 8));
         if (k < 8) txq.push_back(w);
      end
      for (c = 0; c < 8; c++) begin
         apb(1'b1, 12'h004, c);
         apb(1'b1, 12'h000, 32'h0000_8000);
         repeat (24) @(posedge clock);
         apb(1'b1, 12'h000, 32'h0000_0000);
         repeat (3) @(posedge clock);
         chk(32'(pins.mclk), 32'h0000_0000);
      end
      // one frame per run, so each fifo word is checked at its own load
      {sl, sr} = 2'b00;
      for (k = 0; k < 8; k++) begin
         c = (k == 7) ? 32'h0000_0000 : 32'h0003_0000;
         apb(1'b1, 12'h00C, 32'h0000_0003);
         w = txq.pop_front();
         fl = (k < 7) && (w[31:16] == 16'h0000 || w[31] != sl);
         fr = (k < 7) && (w[15:0] == 16'h0000 || w[15] != sr);
         {sl, sr} = {w[31], w[15]};
         apb(1'b1, 12'h000, c | 32'h0000_0001);
         repeat (6) @(posedge clock);
         chk(32'(lzc), 32'(fl));
         chk(32'(rzc), 32'(fr));
         // one bit period in: bit clock low, left half, second msb out
         chk(32'({pins.bclk, pins.lrclk, pins.sdo}), 32'({2'b00, w[30]}));
         apb(1'b1, 12'h000, c);
         repeat (10) @(posedge clock);
      end
      apb(1'b1, 12'h000, 32'h0000_0001);
      repeat (2000) @(posedge clock);
      for (c = 0; c < 8; c++) begin
         apb(1'b1, 12'h000, (c << 12) | (c << 9) | 32'h0000_0001);
         repeat (2) @(posedge clock);
         chk(32'(rxf), 32'h0000_0001);
         chk(32'(txf), 32'h0000_0001);
      end
      // rx fifo full at eight, tx empty, both zero-cross flags clear
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_008C);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk(32'(err), 32'h0000_0000);
      end_of_test();
   end
endmodule // aszc_ctl_test
